//--- src/sem_host.sv
// host controller for one port of a dual-port semaphore block
// assumes device pins are synchronous to REF_CLK and the far port exists
`timescale 1ns/1ps
module sem_host (
    // clock and reset
    input  wire logic                          REF_CLK,
    input  wire logic                          SYS_RST,
    // user command port
    input  wire logic                          REQ_VALID,
    input  wire sem_host_pkg::req_type         REQ,
    output logic                               REQ_READY,
    output logic                               DONE,
    output logic                               GRANTED,
    output logic                               INIT_DONE,
    // device pins
    output sem_host_pkg::pins_type             PINS,
    input  wire logic [sem_host_pkg::DATA_W-1:0] DATA_IN
);
    typedef enum logic [2:0] {
        S_INIT, S_IDLE, S_WRITE, S_GAP, S_READ, S_FINISH
    } state_type;

    state_type                          state;
    state_type                          next_state;
    sem_host_pkg::cmd_type              cmd;
    logic [sem_host_pkg::INDEX_W-1:0]   flag;
    logic                               wvalue;
    logic                               initialized;
    logic                               start;
    logic                               timer_done;
    logic [sem_host_pkg::CNT_W-1:0]     length;
    logic                               owned;
    logic                               write_phase;
    logic                               read_phase;
    logic                               do_read;
    logic                               accept;

    // claim is write-then-read; release only writes; poll only reads
    assign do_read     = (cmd != sem_host_pkg::CMD_RELEASE)
                       && (cmd != sem_host_pkg::CMD_INIT);
    assign accept      = (state == S_IDLE) && REQ_VALID;
    assign REQ_READY   = (state == S_IDLE);
    assign write_phase = (state == S_WRITE);
    assign read_phase  = (state == S_READ);
    // all data bits carry the flag; sample bit zero, zero means owned
    assign owned       = ~DATA_IN[0];
    // the timer is loaded for the phase about to begin, so its length
    // follows the next state; keying it on the current one swaps widths
    assign length      = (next_state == S_GAP)
                       ? sem_host_pkg::CNT_W'(sem_host_pkg::GAP_CYC)
                       : sem_host_pkg::CNT_W'(sem_host_pkg::STROBE_CYC);

    // phase sequencing
    always_comb
    begin
        next_state = state;
        start      = 1'b0;
        case (state)
            S_INIT:
            begin
                // start the first release strobe on the timer at once via S_WRITE
                next_state = S_WRITE;
                start      = 1'b1;
            end
            S_IDLE:
                if (accept)
                begin
                    // a poll skips the write; a claim writes first
                    next_state = (REQ.cmd == sem_host_pkg::CMD_POLL)
                               ? S_READ : S_WRITE;
                    start      = 1'b1;
                end
            S_WRITE:
                if (timer_done)
                begin
                    next_state = S_GAP;
                    start      = 1'b1;
                end
            S_GAP:
                if (timer_done)
                begin
                    if (do_read)
                    begin
                        next_state = S_READ;
                        start      = 1'b1;
                    end
                    else if (!initialized)
                    begin
                        next_state = (flag == sem_host_pkg::LAST_INDEX)
                                   ? S_FINISH : S_WRITE;
                        start      = (flag != sem_host_pkg::LAST_INDEX);
                    end
                    else
                        next_state = S_FINISH;
                end
            S_READ:
                if (timer_done)
                begin
                    // selects drop again before any next read
                    next_state = S_FINISH;
                end
            default:
                next_state = S_IDLE;
        endcase
    end

    sem_strobe_timer #(
        .WIDTH (sem_host_pkg::CNT_W)
    ) u_timer (
        .clk    (REF_CLK),
        .rst    (SYS_RST),
        .start  (start),
        .length (length),
        .done   (timer_done)
    );

    // state, command latch and results
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            state       <= S_INIT;
            cmd         <= sem_host_pkg::CMD_INIT;
            flag        <= '0;
            wvalue      <= 1'b1;
            initialized <= 1'b0;
            GRANTED     <= 1'b0;
            DONE        <= 1'b0;
        end
        else
        begin
            state <= next_state;
            DONE  <= 1'b0;
            if (accept)
            begin
                cmd    <= REQ.cmd;
                flag   <= REQ.flag;
                // zero claims, one releases
                wvalue <= (REQ.cmd == sem_host_pkg::CMD_RELEASE);
            end
            // power-up: write one to each flag in turn
            if (!initialized && state == S_GAP && timer_done
                && flag != sem_host_pkg::LAST_INDEX)
                flag <= flag + sem_host_pkg::INDEX_W'(1);
            if (read_phase && timer_done)
                GRANTED <= owned;
            if (state == S_FINISH)
            begin
                initialized <= 1'b1;
                DONE        <= initialized;
            end
        end
    end

    assign INIT_DONE = initialized;

    // pin drive: semaphore space only, memory select held off
    always_comb
    begin
        PINS                     = '0;
        PINS.semaphore_select_n  = ~(write_phase | read_phase);
        PINS.mem_select_n        = 1'b1;
        PINS.write_n             = ~write_phase;
        PINS.read_enable_n       = ~read_phase;
        PINS.byte_lane_selects_n = read_phase ? 2'h0 : 2'h3;
        PINS.addr                = sem_host_pkg::ADDR_W'(flag);
        PINS.wdata               = {sem_host_pkg::DATA_W{wvalue}};
        PINS.data_oe             = write_phase;
    end

    // a failed claim leaves a pending request; user must poll or release
    // the memory array stays deselected through every flag access
    a_sem_exclusive: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        !PINS.semaphore_select_n |-> PINS.mem_select_n)
        else $error("memory select active during semaphore access");
    // write and read strobes never overlap
    a_read_not_write: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        !(~PINS.write_n && ~PINS.read_enable_n))
        else $error("write and read strobes overlap");
    // a claim always reads back right after its gap
    a_claim_then_read: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        (state == S_GAP && cmd == sem_host_pkg::CMD_CLAIM && timer_done)
        |=> !PINS.read_enable_n)
        else $error("claim not followed by readback");
    // each read strobe ends after its two-cycle width, so the next read
    // captures a fresh value in the device output latch
    a_read_strobe_drops: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        $fell(PINS.read_enable_n) |-> ##2 PINS.read_enable_n)
        else $error("read strobe held past its width");
    // upper address lines stay quiet so only the flag index matters
    a_flag_addr_only: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        !PINS.semaphore_select_n
        |-> (PINS.addr[sem_host_pkg::ADDR_W-1:sem_host_pkg::INDEX_W] == '0))
        else $error("upper address lines driven during flag access");
    // a claim writes zero on data bit zero
    a_claim_writes_zero: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        (!PINS.write_n && cmd == sem_host_pkg::CMD_CLAIM)
        |-> !PINS.wdata[0])
        else $error("claim did not write zero");
    // power-up writes always free the flag
    a_init_writes_one: assert property (
        @(posedge REF_CLK) disable iff (SYS_RST)
        (!PINS.write_n && !initialized) |-> PINS.wdata[0])
        else $error("power-up write did not free the flag");
endmodule : sem_host

//--- src/sem_host_pkg.sv
// semaphore host package: pin bundles, commands, timing counts
// assumes a 20 MHz system clock driving the controller
package sem_host_pkg;
    localparam int CLK_NS        = 50;
    localparam int DATA_W        = 18;
    localparam int INDEX_W       = 3;
    localparam int FLAG_COUNT    = 8;
    localparam int ADDR_W        = 18;
    // strobe widths in ns, rounded up to whole clock cycles
    localparam int STROBE_NS     = 60;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_NS        = 50;
    localparam int GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 4;
    localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;

    typedef enum logic [1:0] {
        CMD_CLAIM,
        CMD_RELEASE,
        CMD_POLL,
        CMD_INIT
    } cmd_type;

    // pins toward one port of the dual-port device
    typedef struct packed {
        logic              semaphore_select_n;
        logic              mem_select_n;
        logic              write_n;
        logic              read_enable_n;
        logic [1:0]        byte_lane_selects_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              data_oe;
    } pins_type;

    typedef struct packed {
        cmd_type              cmd;
        logic [INDEX_W-1:0]   flag;
    } req_type;
endpackage : sem_host_pkg

//--- src/sem_strobe_timer.sv
// strobe timer: counts down a loaded number of clock cycles and flags the end
// assumes one clock; start only while idle or in the done cycle
`timescale 1ns/1ps
module sem_strobe_timer #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] length,
    output logic                  done
);
    logic [WIDTH-1:0] count;
    logic             busy;
    logic [WIDTH-1:0] next_count;

    assign next_count = count - WIDTH'(1);
    assign done       = busy && (count == '0);

    // load on start, count down to zero, then one done pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            busy  <= 1'b0;
        end
        else if (start)
        begin
            count <= length - WIDTH'(1);
            busy  <= 1'b1;
        end
        else if (done)
            busy <= 1'b0;
        else if (busy)
            count <= next_count;
    end
endmodule : sem_strobe_timer

//--- verif/sem_flag_model.sv
// behavioural model of the eight-flag semaphore space of a dual-port device
// assumes host pins change only after REF_CLK edges; far port is tb driven
`timescale 1ns/1ps
module sem_flag_model (
    // clock
    input  wire logic                            clk,
    // near port pins
    input  wire sem_host_pkg::pins_type          pins,
    output logic [sem_host_pkg::DATA_W-1:0]      data_out,
    // far port, one write per pulse
    input  wire logic                            far_write,
    input  wire logic [2:0]                      far_idx,
    input  wire logic                            far_val,
    output logic                                 far_flag
);
    // owner per flag: 0 free, 1 near, 2 far; x until both sides wrote one
    logic [1:0] own [8];
    logic [7:0] ra;
    logic [7:0] rb;
    logic       rd_q;
    logic       hold;
    logic       latch;
    logic [sem_host_pkg::DATA_W-1:0] last;
    // memory select is never consulted: flags gate nothing
    wire        wr = !pins.semaphore_select_n && !pins.write_n;
    wire [2:0]  ai = pins.addr[2:0];
    wire        rd = !pins.semaphore_select_n && !pins.read_enable_n
                     && pins.byte_lane_selects_n != 2'h3;

    // request latches feed the flag; first zero wins, release hands over
    task automatic settle(input int i);
        case (own[i])
            2'h0: if (!ra[i]) own[i] = 2'h1; else if (!rb[i]) own[i] = 2'h2;
            2'h1: if (ra[i]) own[i] = rb[i] ? 2'h0 : 2'h2;
            2'h2: if (rb[i]) own[i] = ra[i] ? 2'h0 : 2'h1;
            default: if (ra[i] === 1'b1 && rb[i] === 1'b1) own[i] = 2'h0;
        endcase
    endtask : settle

    // near side first on the same edge: a tie goes to one side only
    always @(posedge clk)
    begin
        if (wr)
        begin
            ra[ai] = pins.wdata[0];
            settle(ai);
        end
        if (far_write)
        begin
            rb[far_idx] = far_val;
            settle(far_idx);
        end
        rd_q  <= rd;
        latch <= hold;
        last  <= data_out;
    end

    // read value is frozen from the first active cycle on
    assign hold = rd_q ? latch : (own[ai] !== 2'h1);
    assign far_flag = (own[far_idx] !== 2'h2);
    // lanes gate outputs and rd; a released lane shows the inverse of last
    always_comb
    begin
        for (int k = 0; k < sem_host_pkg::DATA_W; k++)
            data_out[k] = (rd && !pins.byte_lane_selects_n[k / 9])
                          ? hold : ~last[k];
    end
endmodule : sem_flag_model

//--- verif/testbench.sv
// self-checking bench: host controller against the flag model
// assumes the far port is driven directly by the bench tasks below
`timescale 1ns/1ps
module testbench;
    logic                   REF_CLK = 1'b0;
    logic                   SYS_RST = 1'b1;
    logic                   REQ_VALID = 1'b0;
    sem_host_pkg::req_type  REQ = '0;
    logic                   REQ_READY;
    logic                   DONE;
    logic                   GRANTED;
    logic                   INIT_DONE;
    sem_host_pkg::pins_type PINS;
    logic [sem_host_pkg::DATA_W-1:0] DATA_IN;
    logic                   fw = 1'b0;
    logic [2:0]             fi = 3'h0;
    logic                   fv = 1'b1;
    logic                   ff;
    int                     fail_count = 0;
    int                     comparisons = 0;
    int                     cycles = 0;

    always #25 REF_CLK = ~REF_CLK;

    sem_host u_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
        .DONE(DONE), .GRANTED(GRANTED), .INIT_DONE(INIT_DONE),
        .PINS(PINS), .DATA_IN(DATA_IN));
    sem_flag_model u_dev (.clk(REF_CLK), .pins(PINS), .data_out(DATA_IN),
        .far_write(fw), .far_idx(fi), .far_val(fv), .far_flag(ff));

    task automatic results;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic check(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check

    // far side write, one cycle long, driven off the falling edge
    task automatic far(input logic [2:0] i, input logic v);
        @(negedge REF_CLK);
        fi = i;
        fv = v;
        fw = 1'b1;
        @(negedge REF_CLK);
        fw = 1'b0;
    endtask : far

    task automatic far_read(input logic [2:0] i, input logic exp);
        @(negedge REF_CLK);
        fi = i;
        #1 check(ff, exp);
    endtask : far_read

    // one command; GRANTED judged once DONE has landed
    task automatic cmd(input sem_host_pkg::cmd_type c, input logic [2:0] f,
                       input logic exp);
        int n;
        n = 0;
        @(negedge REF_CLK);
        while (REQ_READY !== 1'b1 && n < 50)
        begin
            @(negedge REF_CLK);
            n++;
        end
        REQ.cmd = c;
        REQ.flag = f;
        REQ_VALID = 1'b1;
        @(negedge REF_CLK);
        REQ_VALID = 1'b0;
        check(REQ_READY, 1'b0);
        n = 0;
        while (DONE !== 1'b1 && n < 30)
        begin
            @(negedge REF_CLK);
            n++;
        end
        check(DONE, 1'b1);
        check(GRANTED, exp);
    endtask : cmd

    // near claims, far waits, release hands over at once
    task automatic t_handover;
        cmd(sem_host_pkg::CMD_CLAIM, 3'h3, 1'b1);
        far_read(3'h3, 1'b1);
        far(3'h3, 1'b0);
        cmd(sem_host_pkg::CMD_POLL, 3'h3, 1'b1);
        cmd(sem_host_pkg::CMD_RELEASE, 3'h3, 1'b1);
        far_read(3'h3, 1'b0);
        cmd(sem_host_pkg::CMD_POLL, 3'h3, 1'b0);
        far(3'h3, 1'b1);
        cmd(sem_host_pkg::CMD_POLL, 3'h3, 1'b0);
        far_read(3'h3, 1'b1);
    endtask : t_handover

    // far holds, near claim fails but stays latched, then takes over
    task automatic t_pending;
        far(3'h5, 1'b0);
        cmd(sem_host_pkg::CMD_CLAIM, 3'h5, 1'b0);
        far(3'h5, 1'b1);
        cmd(sem_host_pkg::CMD_POLL, 3'h5, 1'b1);
        cmd(sem_host_pkg::CMD_RELEASE, 3'h5, 1'b1);
        far_read(3'h5, 1'b1);
    endtask : t_pending

    // every index reaches its own flag only
    task automatic t_indexes;
        for (int i = 0; i < sem_host_pkg::FLAG_COUNT; i++)
        begin
            cmd(sem_host_pkg::CMD_CLAIM, 3'(i), 1'b1);
            far_read(3'(i), 1'b1);
            far_read(3'(i + 1), 1'b1);
            // the neighbour must still read free from this side
            cmd(sem_host_pkg::CMD_POLL, 3'(i + 1), 1'b0);
            // release does not read, so the poll result still stands
            cmd(sem_host_pkg::CMD_RELEASE, 3'(i), 1'b0);
        end
    endtask : t_indexes

    // hang guard reckoned from thirty-two commands of about ten cycles
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            fail_count++;
            results();
        end
    end

    initial
    begin
        // reset for five cycles; the far side then frees its latches
        // while the host runs its own power-up writes
        repeat (5) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        for (int i = 0; i < 8; i++)
            far(3'(i), 1'b1);
        for (int n = 0; n < 100 && INIT_DONE !== 1'b1; n++)
            @(negedge REF_CLK);
        check(INIT_DONE, 1'b1);
        for (int i = 0; i < 8; i++)
            far_read(3'(i), 1'b1);
        t_handover();
        t_pending();
        t_indexes();
        results();
    end
endmodule : testbench
